// ==== include/tas_defs.vh ====
`ifndef TAS_DEFS_VH
`define TAS_DEFS_VH

// register map (byte addresses, one aligned word each)
`define TAS_ADDR_STATUS 12'h000
`define TAS_ADDR_CFG 12'h004
`define TAS_ADDR_W 12

// status word field positions
`define TAS_NONSECURE_NONINVASIVE_STATE_FIELD_LO 2
`define TAS_NONSECURE_NONINVASIVE_STATE_FIELD_HI 3
`define TAS_SID_LO 4
`define TAS_SID_HI 5
`define TAS_SECURE_NONINVASIVE_STATE_FIELD_LO 6
`define TAS_SECURE_NONINVASIVE_STATE_FIELD_HI 7
`define TAS_HID_LO 8
`define TAS_HID_HI 9
`define TAS_EL2_NONINVASIVE_STATE_FIELD_LO 10
`define TAS_EL2_NONINVASIVE_STATE_FIELD_HI 11

// two-bit field codes
`define TAS_CODE_ABSENT 2'h0
`define TAS_CODE_OFF 2'h2
`define TAS_CODE_ON 2'h3

// status value loaded on trace reset, fixed per build
`define TAS_STATUS_RESET 32'h0000_0000

// axi response codes
`define TAS_RESP_OKAY 2'h0
`define TAS_RESP_SLVERR 2'h2

// cfg register: bit 0 enables el2 trace suppression gate
`define TAS_CFG_GATE_BIT 0
`define TAS_CFG_RESET 32'h0000_0001

// el2 prohibited flag and gate bit after reset: closed until proven open
`define TAS_PROHIB_RESET 1'b1
`define TAS_GATE_RESET 1'b1

`endif

// ==== hw/tas_sync2.v ====
`timescale 1ns/100ps
`include "tas_defs.vh"

// two-flop synchroniser, one per bit of a bus of pin levels
module tas_sync2 #(
    parameter W = 4
) (
    mclk,
    rst,
    din,
    dout
);
    input wire mclk;
    input wire rst;
    input wire [W-1:0] din;
    output wire [W-1:0] dout;

    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    // first stage is read only by the second stage
    genvar gi;
    generate
        for (gi = 0; gi < W; gi = gi + 1) begin : g_bit
            always @(posedge mclk or posedge rst) begin
                if (rst) begin
                    meta_q[gi] <= 1'b0;
                    sync_q[gi] <= 1'b0;
                end else begin
                    meta_q[gi] <= din[gi];
                    sync_q[gi] <= meta_q[gi];
                end
            end
        end
    endgenerate

    assign dout = sync_q;
endmodule

// ==== hw/tas_auth_status.v ====
// Operation
// - software reads current permitted trace level
// - optional el2 invasive, noninvasive enable inputs
// - both el2 enables low prohibits el2 tracing
// - without el2 enables, nonsecure inputs govern el2
// - el2 invasive needs nonsecure invasive permitted
// - el2 noninvasive needs nonsecure noninvasive permitted
// - status word 32-bit read-only, writes ignored
// - trace reset loads fixed build-time value
// - nonsecure noninvasive field presence is build option
// - el2 noninvasive field bits 11:10, 10 off 11 on
// - el2 noninvasive field 00 when no separate enable
// - real-time profile: field shows el2 permission
// - other profiles: el2 noninvasive field fixed 00
// - el2 invasive field bits 9:8 reads 00
// - nonsecure noninvasive field bits 3:2 encodings
// - secure invasive field bits 5:4 reads 00
`timescale 1ns/100ps
`include "tas_defs.vh"

module tas_auth_status #(
    parameter HAS_EL2_EN = 1,
    parameter HAS_NONSECURE_NONINVASIVE_STATE_FIELD = 1,
    parameter RT_PROFILE = 1
) (
    mclk,
    rst,
    trace_rst,
    nonsecure_invasive_enable,
    nonsecure_noninvasive_enable,
    el2_invasive_enable,
    el2_noninvasive_enable,
    pe_at_el2,
    trace_valid_in,
    trace_valid_out,
    el2_trace_prohibited,
    s_axi_awaddr,
    s_axi_awvalid,
    s_axi_awready,
    s_axi_wdata,
    s_axi_wstrb,
    s_axi_wvalid,
    s_axi_wready,
    s_axi_bresp,
    s_axi_bvalid,
    s_axi_bready,
    s_axi_araddr,
    s_axi_arvalid,
    s_axi_arready,
    s_axi_rdata,
    s_axi_rresp,
    s_axi_rvalid,
    s_axi_rready
);
    input wire mclk;
    input wire rst;
    input wire trace_rst;
    input wire nonsecure_invasive_enable;
    input wire nonsecure_noninvasive_enable;
    input wire el2_invasive_enable;
    input wire el2_noninvasive_enable;
    input wire pe_at_el2;
    input wire trace_valid_in;
    output wire trace_valid_out;
    output wire el2_trace_prohibited;
    input wire [`TAS_ADDR_W-1:0] s_axi_awaddr;
    input wire s_axi_awvalid;
    output wire s_axi_awready;
    input wire [31:0] s_axi_wdata;
    input wire [3:0] s_axi_wstrb;
    input wire s_axi_wvalid;
    output wire s_axi_wready;
    output wire [1:0] s_axi_bresp;
    output wire s_axi_bvalid;
    input wire s_axi_bready;
    input wire [`TAS_ADDR_W-1:0] s_axi_araddr;
    input wire s_axi_arvalid;
    output wire s_axi_arready;
    output wire [31:0] s_axi_rdata;
    output wire [1:0] s_axi_rresp;
    output wire s_axi_rvalid;
    input wire s_axi_rready;

    // ***********************************************************
    // authentication input synchronisers
    // ***********************************************************

    wire [3:0] auth_raw;
    wire [3:0] auth_s;
    wire ns_inv;
    wire ns_ninv;
    wire el2_inv_pin;
    wire el2_ninv_pin;

    assign auth_raw = {el2_noninvasive_enable, el2_invasive_enable,
                       nonsecure_noninvasive_enable, nonsecure_invasive_enable};

    // enables come from another block's timing, so resynchronise them
    tas_sync2 #(
        .W(4)
    ) u_sync (
        .mclk(mclk),
        .rst(rst),
        .din(auth_raw),
        .dout(auth_s)
    );

    assign ns_inv = auth_s[0];
    assign ns_ninv = auth_s[1];
    assign el2_inv_pin = auth_s[2];
    assign el2_ninv_pin = auth_s[3];

    // ***********************************************************
    // permission logic
    // ***********************************************************

    wire el2_inv_ok;
    wire el2_ninv_ok;
    wire el2_trace_ok;

    // el2 enables never widen what nonsecure permits
    generate
        if (HAS_EL2_EN != 0) begin : g_el2
            assign el2_inv_ok = el2_inv_pin & ns_inv;
            assign el2_ninv_ok = el2_ninv_pin & ns_ninv;
            // both el2 pins low prohibits tracing at el2; the el2 invasive pin
            // counts only while nonsecure invasive debug is permitted too
            assign el2_trace_ok = (el2_inv_ok & ns_ninv) | el2_ninv_ok;
        end else begin : g_noel2
            // el2 pins ignored; the nonsecure enables alone decide
            assign el2_inv_ok = ns_inv;
            assign el2_ninv_ok = ns_ninv;
            assign el2_trace_ok = ns_ninv;
        end
    endgenerate

    // ***********************************************************
    // status word assembly
    // ***********************************************************

    reg [1:0] nonsecure_noninvasive_state_field_code;
    reg [1:0] el2_noninvasive_state_field_code;
    reg [31:0] status_d;

    // field codes from current permissions
    always @* begin
        if (HAS_NONSECURE_NONINVASIVE_STATE_FIELD != 0) begin
            nonsecure_noninvasive_state_field_code = ns_ninv ? `TAS_CODE_ON : `TAS_CODE_OFF;
        end else begin
            nonsecure_noninvasive_state_field_code = `TAS_CODE_ABSENT;
        end
        if (RT_PROFILE != 0 && HAS_EL2_EN != 0) begin
            el2_noninvasive_state_field_code = el2_ninv_ok ? `TAS_CODE_ON : `TAS_CODE_OFF;
        end else begin
            el2_noninvasive_state_field_code = `TAS_CODE_ABSENT;
        end
    end

    // fields placed by name; every bit not listed stays zero
    always @* begin
        status_d = 32'h0000_0000;
        status_d[`TAS_NONSECURE_NONINVASIVE_STATE_FIELD_HI:`TAS_NONSECURE_NONINVASIVE_STATE_FIELD_LO] = nonsecure_noninvasive_state_field_code;
        status_d[`TAS_SID_HI:`TAS_SID_LO] = `TAS_CODE_ABSENT;
        status_d[`TAS_SECURE_NONINVASIVE_STATE_FIELD_HI:`TAS_SECURE_NONINVASIVE_STATE_FIELD_LO] = `TAS_CODE_ABSENT;
        status_d[`TAS_HID_HI:`TAS_HID_LO] = `TAS_CODE_ABSENT;
        status_d[`TAS_EL2_NONINVASIVE_STATE_FIELD_HI:`TAS_EL2_NONINVASIVE_STATE_FIELD_LO] = el2_noninvasive_state_field_code;
    end

    reg [31:0] status_q;

    // registered so a read sees a stable word; trace reset wins
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            status_q <= `TAS_STATUS_RESET;
        end else if (trace_rst) begin
            status_q <= `TAS_STATUS_RESET;
        end else begin
            status_q <= status_d;
        end
    end

    // ***********************************************************
    // control register and el2 trace gate
    // ***********************************************************

    reg gate_q;
    reg prohib_q;
    wire gate_en;

    // gate on by default: prohibited el2 trace is suppressed until software opts out
    assign gate_en = gate_q;

    // registered so the status pin and the gate switch on the same edge
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            prohib_q <= `TAS_PROHIB_RESET;
        end else begin
            prohib_q <= ~el2_trace_ok;
        end
    end

    // gate off is for bring-up only; it lets el2 trace through regardless
    assign el2_trace_prohibited = prohib_q;
    assign trace_valid_out = trace_valid_in &
                             ~(gate_en & pe_at_el2 & prohib_q);

    // ***********************************************************
    // axi4-lite write channel
    // ***********************************************************

    reg aw_got_q;
    reg w_got_q;
    reg [`TAS_ADDR_W-1:0] awaddr_q;
    reg [31:0] wdata_q;
    reg bvalid_q;
    reg [1:0] bresp_q;
    reg wstrb0_q;
    wire aw_hs;
    wire w_hs;
    wire wr_go;
    wire [`TAS_ADDR_W-1:0] wr_addr;
    wire wr_strb0;
    wire wr_bit;
    wire cfg_wr;

    assign s_axi_awready = ~aw_got_q & ~bvalid_q;
    assign s_axi_wready = ~w_got_q & ~bvalid_q;
    assign aw_hs = s_axi_awvalid & s_axi_awready;
    assign w_hs = s_axi_wvalid & s_axi_wready;
    assign wr_go = (aw_got_q | aw_hs) & (w_got_q | w_hs);
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    // the later of address and data decides; the earlier one comes from its hold flop
    assign wr_addr = aw_hs ? s_axi_awaddr : awaddr_q;
    assign wr_strb0 = w_hs ? s_axi_wstrb[0] : wstrb0_q;
    assign wr_bit = w_hs ? s_axi_wdata[`TAS_CFG_GATE_BIT] : wdata_q[`TAS_CFG_GATE_BIT];
    assign cfg_wr = wr_go & (wr_addr == `TAS_ADDR_CFG) & wr_strb0;

    // address and data taken in any order; response after both
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awaddr_q <= {`TAS_ADDR_W{1'b0}};
            wdata_q <= 32'h0000_0000;
            wstrb0_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= `TAS_RESP_OKAY;
        end else begin
            if (aw_hs) begin
                awaddr_q <= s_axi_awaddr;
            end
            if (w_hs) begin
                wdata_q <= s_axi_wdata;
                wstrb0_q <= s_axi_wstrb[0]; // strobe kept for a late address
            end
            if (wr_go) begin
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
                bvalid_q <= 1'b1;
                // status word ignores writes but answers okay
                case (wr_addr)
                    `TAS_ADDR_STATUS: begin
                        bresp_q <= `TAS_RESP_OKAY;
                    end
                    `TAS_ADDR_CFG: begin
                        bresp_q <= `TAS_RESP_OKAY;
                    end
                    default: begin
                        bresp_q <= `TAS_RESP_SLVERR;
                    end
                endcase
            end else begin
                if (aw_hs) begin
                    aw_got_q <= 1'b1;
                end
                if (w_hs) begin
                    w_got_q <= 1'b1;
                end
                if (bvalid_q && s_axi_bready) begin
                    bvalid_q <= 1'b0;
                end
            end
        end
    end

    // ***********************************************************
    // cfg gate register
    // ***********************************************************

    // gate bit lives apart from the bus state; only a strobed cfg write moves it
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            gate_q <= `TAS_GATE_RESET;
        end else if (cfg_wr) begin
            gate_q <= wr_bit;
        end
    end

    // ***********************************************************
    // axi4-lite read channel
    // ***********************************************************

    reg rvalid_q;
    reg [31:0] rdata_q;
    reg [1:0] rresp_q;
    wire ar_hs;

    assign s_axi_arready = ~rvalid_q;
    assign ar_hs = s_axi_arvalid & s_axi_arready;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    // one read outstanding; data registered at address acceptance
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= `TAS_RESP_OKAY;
        end else if (ar_hs) begin
            rvalid_q <= 1'b1;
            case (s_axi_araddr)
                `TAS_ADDR_STATUS: begin
                    rdata_q <= status_q;
                    rresp_q <= `TAS_RESP_OKAY;
                end
                `TAS_ADDR_CFG: begin
                    rdata_q <= {31'h0, gate_q};
                    rresp_q <= `TAS_RESP_OKAY;
                end
                default: begin
                    rdata_q <= 32'h0000_0000;
                    rresp_q <= `TAS_RESP_SLVERR;
                end
            endcase
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end
endmodule

// ==== test/tas_auth_src.sv ====
`timescale 1ns/100ps
// ********************************
// authentication source model
// ********************************
module tas_auth_src (
    input wire mclk,
    input wire [3:0] sel,
    output logic nonsecure_invasive_enable = 1'b0,
    output logic nonsecure_noninvasive_enable = 1'b0,
    output logic el2_invasive_enable = 1'b0,
    output logic el2_noninvasive_enable = 1'b0
);
    // registered levels, so every change lands one edge after the request
    always @(posedge mclk) begin
        nonsecure_invasive_enable <= sel[0];
        nonsecure_noninvasive_enable <= sel[1];
        el2_invasive_enable <= sel[2];
        el2_noninvasive_enable <= sel[3];
    end
endmodule

// ==== test/tas_auth_status_chk.sv ====
`timescale 1ns/100ps
// ********************************
// port checker
// ********************************
module tas_auth_status_chk (
    input wire mclk,
    input wire rst,
    input wire nonsecure_invasive_enable,
    input wire nonsecure_noninvasive_enable,
    input wire el2_invasive_enable,
    input wire el2_noninvasive_enable,
    input wire pe_at_el2,
    input wire trace_valid_in,
    input wire trace_valid_out,
    input wire el2_trace_prohibited,
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    logic [1:0] up_q;
    logic [11:0] ar_q;
    wire inv_w = el2_invasive_enable & nonsecure_invasive_enable;
    wire ok_w = (inv_w | el2_noninvasive_enable) & nonsecure_noninvasive_enable;
    wire inv_only_w = !el2_noninvasive_enable && !nonsecure_invasive_enable;
    wire low_w = !el2_invasive_enable && !el2_noninvasive_enable;
    wire st_w = s_axi_rvalid && ar_q == 12'h000;
    // age since reset: sync plus flag flop mean nothing for the first three edges
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            up_q <= 2'h0;
            ar_q <= 12'h000;
        end else begin
            if (up_q != 2'h3) up_q <= up_q + 2'h1;
            if (s_axi_arvalid && s_axi_arready) ar_q <= s_axi_araddr;
        end
    end
    tv_gate_a: assert property (trace_valid_out |-> trace_valid_in)
        else $error("trace item out without one in");
    tv_pass_a: assert property (!pe_at_el2 |-> trace_valid_out == trace_valid_in)
        else $error("trace dropped outside el2");
    both_low_a: assert property (
        up_q == 2'h3 && $past(low_w, 3) |-> el2_trace_prohibited)
        else $error("el2 trace allowed with both el2 enables low");
    ns_need_a: assert property (
        up_q == 2'h3 && !$past(nonsecure_noninvasive_enable, 3) |-> el2_trace_prohibited)
        else $error("el2 trace allowed without nonsecure permission");
    ns_inv_need_a: assert property (
        up_q == 2'h3 && $past(inv_only_w, 3) |-> el2_trace_prohibited)
        else $error("el2 invasive enable used without nonsecure invasive");
    el2_ok_a: assert property (
        up_q == 2'h3 && $past(ok_w, 3) |-> !el2_trace_prohibited)
        else $error("el2 trace prohibited although permitted");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    rd_done_a: assert property (
        s_axi_rvalid && s_axi_rready && !s_axi_arvalid |=> !s_axi_rvalid)
        else $error("read answer repeated");
    st_okay_a: assert property (st_w |-> s_axi_rresp == 2'h0)
        else $error("status read refused");
    res_zero_a: assert property (st_w |-> s_axi_rdata[31:12] == 20'h00000)
        else $error("status upper bits not zero");
    sec_zero_a: assert property (st_w |-> s_axi_rdata[9:4] == 6'h00)
        else $error("status fixed fields not zero");
    cover property (s_axi_arvalid && s_axi_arready);
    cover property (pe_at_el2 && el2_trace_prohibited && trace_valid_in);
    cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule
bind tas_auth_status tas_auth_status_chk u_chk (.*);

// ==== test/tb_trace_auth_status.sv ====
`timescale 1ns/100ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin failures++; \
    $display("wrong value at %0t got %h expected %h", $time, g, e); end end
// ********************************
// bench
// ********************************
module tb_trace_auth_status;
    logic mclk = 1'b0, rst = 1'b1, trace_rst = 1'b0, pe_at_el2 = 1'b0, trace_valid_in = 1'b0;
    logic [3:0] sel = 4'h0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire trace_valid_out, el2_trace_prohibited;
    wire nonsecure_invasive_enable, nonsecure_noninvasive_enable;
    wire el2_invasive_enable, el2_noninvasive_enable;
    int failures = 0, samples_checked = 0;
    logic [31:0] d;
    logic [1:0] r;
    tas_auth_src src (.*);
    tas_auth_status dut (.*);
    // free-running clock, 50 ns period
    initial begin
        forever #25 mclk = ~mclk;
    end
    task print_verdict;
        if (failures == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // a spent wait bound ends the run as a failure
    task tmo(input int n);
        if (n >= 50) begin
            failures++;
            print_verdict;
        end
    endtask
    task axi_rd(input [11:0] a, output [31:0] rd, output [1:0] rr);
        int n;
        n = 0;
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (!s_axi_arready && n < 50);
        s_axi_arvalid <= 1'b0;
        while (!s_axi_rvalid && n < 50) begin
            @(posedge mclk);
            n++;
        end
        tmo(n);
        rd = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // address and data offered together, each dropped once taken
    task axi_wr(input [11:0] a, input [31:0] wd, output [1:0] rr);
        int n;
        n = 0;
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= wd;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 50);
        tmo(n);
        rr = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    // partner edge plus two sync edges plus status register, with margin
    task set_levels(input [3:0] s);
        @(posedge mclk);
        sel <= s;
        repeat (6) @(posedge mclk);
    endtask
    task t_trace_reset;
        @(posedge mclk);
        trace_rst <= 1'b1;
        axi_rd(12'h000, d, r);
        `CHK(d, 32'h0)
        trace_rst <= 1'b0;
    endtask
    // every combination of the four enables, at el2 with trace present
    task t_levels;
        logic ok;
        pe_at_el2 <= 1'b1;
        trace_valid_in <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            set_levels(i[3:0]);
            ok = ((sel[2] & sel[0]) | sel[3]) & sel[1];
            `CHK(el2_trace_prohibited, !ok)
            `CHK(trace_valid_out, ok)
            axi_rd(12'h000, d, r);
            `CHK(r, 2'h0)
            `CHK(d, {20'h0, (sel[1] & sel[3]) ? 2'h3 : 2'h2, 6'h0, sel[1] ? 2'h3 : 2'h2, 2'h0})
        end
        @(posedge mclk);
        pe_at_el2 <= 1'b0;
        @(posedge mclk);
        @(posedge mclk);
        `CHK(trace_valid_out, 1'b1)
        trace_valid_in <= 1'b0;
    endtask
    task t_write_ro;
        set_levels(4'hf);
        axi_wr(12'h000, 32'hffff_ffff, r);
        `CHK(r, 2'h0)
        axi_rd(12'h000, d, r);
        `CHK(d, 32'h0000_0c0c)
    endtask
    // gate bit: reset on, off lets prohibited el2 trace through, strobe guards it
    task t_gate;
        set_levels(4'h0);
        pe_at_el2 <= 1'b1;
        trace_valid_in <= 1'b1;
        axi_rd(12'h004, d, r);
        `CHK(d, 32'h1)
        `CHK(trace_valid_out, 1'b0)
        axi_wr(12'h004, 32'h0, r);
        `CHK(r, 2'h0)
        axi_rd(12'h004, d, r);
        `CHK(d, 32'h0)
        `CHK(el2_trace_prohibited, 1'b1)
        `CHK(trace_valid_out, 1'b1)
        s_axi_wstrb <= 4'he;
        axi_wr(12'h004, 32'h1, r);
        s_axi_wstrb <= 4'hf;
        axi_rd(12'h004, d, r);
        `CHK(d, 32'h0)
        axi_wr(12'h004, 32'h1, r);
        axi_rd(12'h004, d, r);
        `CHK(d, 32'h1)
        `CHK(trace_valid_out, 1'b0)
        axi_wr(12'h008, 32'h1, r);
        `CHK(r, 2'h2)
        pe_at_el2 <= 1'b0;
        @(posedge mclk);
        `CHK(trace_valid_out, 1'b1)
        trace_valid_in <= 1'b0;
    endtask
    task t_unmapped;
        axi_rd(12'h008, d, r);
        `CHK(r, 2'h2)
        `CHK(d, 32'h0)
    endtask
    initial begin
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        t_trace_reset;
        t_levels;
        t_write_ro;
        t_gate;
        t_unmapped;
        print_verdict;
    end
endmodule
